// >>> rtl/ddr_pin_if.sv
// Dual-rank DDR2 device pin behaviour: decode, power states, data pins
`timescale 1ns/1ns
`default_nettype none
`include "ddr_cfg.svh"
module ddr_pin_if #(
  parameter int DQW  = `DDR_DQW,
  parameter int COLW = `DDR_COLW,
  parameter int RL   = `DDR_RL
) (
  // System
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Differential clock
  input  wire logic                   ck,
  input  wire logic                   ckN,
  // Per-rank control
  input  wire logic [`DDR_NRANK-1:0]  cke,
  input  wire logic [`DDR_NRANK-1:0]  csN,
  input  wire logic [`DDR_NRANK-1:0]  odt,
  // Command and address
  input  wire logic                   rasN,
  input  wire logic                   casN,
  input  wire logic                   weN,
  input  wire logic [`DDR_BAW-1:0]    ba,
  input  wire logic [`DDR_AW-1:0]     addr,
  // Data pins
  input  wire logic [DQW-1:0]         dqIn,
  output var  logic [DQW-1:0]         dqOut,
  output var  logic                   dqOe,
  input  wire logic                   dqsIn,
  output var  logic                   dqsOut,
  output var  logic                   dqsOe,
  output var  logic                   dqsNOut,
  output var  logic                   dqsNOe,
  input  wire logic                   dm,
  // Rank status
  output var  logic [`DDR_NRANK-1:0]  odtOn,
  output var  logic [`DDR_NRANK-1:0]  clkActive,
  output var  logic [`DDR_NRANK-1:0]  inBufOn
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (!(DQW == 4 || DQW == 8)) begin : g_badDqw
    $error("DQW must be 4 or 8");
  end
  if (RL < 1 || RL > 15) begin : g_badRl
    $error("RL must be 1 to 15");
  end
  if (COLW < 2 || COLW > 8) begin : g_badCol
    $error("COLW must be 2 to 8");
  end

  localparam int NR = `DDR_NRANK;
  localparam int IW = 1 + `DDR_BAW + COLW;
  localparam int SW = 2 + 3 * NR + 3 + `DDR_BAW + `DDR_AW + DQW + 2;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock crossings
  // ----------------------------------------------------------------
  logic [SW-1:0]          pinS;
  logic                   ckS;
  logic                   ckNS;
  logic [NR-1:0]          ckeS;
  logic [NR-1:0]          csNS;
  logic [NR-1:0]          odtS;
  logic                   rasNS;
  logic                   casNS;
  logic                   weNS;
  logic [`DDR_BAW-1:0]    baS;
  logic [`DDR_AW-1:0]     addrS;
  logic [DQW-1:0]         dqS;
  logic                   dqsS;
  logic                   dmS;
  logic                   ckS_r;
  logic                   dqsS_r;
  logic                   ckRise;
  logic                   ckEdge;
  logic                   dqsEdge;
  ddr_pkg::ddr_cmd_t      cmd;

  // Data and strobe share one synchroniser so their skew is preserved
  ddr_sync #(.W(SW)) u_pinSync (
    .clk   (clk),
    .reset (reset),
    .d     ({ck, ckN, cke, csN, odt, rasN, casN, weN, ba, addr,
             dqIn, dqsIn, dm}),
    .q     (pinS)
  );

  assign {ckS, ckNS, ckeS, csNS, odtS, rasNS, casNS, weNS, baS, addrS,
          dqS, dqsS, dmS} = pinS;

  always_ff @(posedge clk) begin
    if (reset) begin
      ckS_r  <= 1'b0;
      dqsS_r <= 1'b0;
    end else begin
      ckS_r  <= ckS;
      dqsS_r <= dqsS;
    end
  end

  assign ckRise  = ckS & ~ckS_r & ~ckNS;
  assign ckEdge  = ckS ^ ckS_r;
  assign dqsEdge = dqsS ^ dqsS_r;
  assign cmd     = {rasNS, casNS, weNS};

  // ----------------------------------------------------------------
  // Per-rank decode
  // ----------------------------------------------------------------
  ddr_pkg::ddr_pwr_e      pwr_r [NR];
  logic [`DDR_NBANK-1:0]  open_r [NR];
  logic [`DDR_AW-1:0]     mode_r [NR][`DDR_NMR];
  logic [NR-1:0]          liveCmd;
  logic [NR-1:0]          srefCmd;
  logic [NR-1:0]          odtEn;
  logic [NR-1:0]          diffEn;
  logic                   rdHit;
  logic                   wrHit;
  logic                   hitRank;

  always_comb begin
    rdHit   = 1'b0;
    wrHit   = 1'b0;
    hitRank = 1'b0;
    for (int r = 0; r < NR; r++) begin
      // Masked ranks and ranks without input buffers see nothing
      liveCmd[r] = ckRise && pwr_r[r] == ddr_pkg::PWR_ACT && ckeS[r]
                   && !csNS[r];
      srefCmd[r] = ckRise && pwr_r[r] == ddr_pkg::PWR_ACT && !ckeS[r]
                   && !csNS[r] && cmd == `DDR_CMD_REF;
      odtEn[r]   = mode_r[r][`DDR_MR_EXT1][`DDR_RTT_LO]
                   | mode_r[r][`DDR_MR_EXT1][`DDR_RTT_HI];
      diffEn[r]  = !mode_r[r][`DDR_MR_EXT1][`DDR_DQSN_OFF];
      // Controller selects one rank at a time; the higher rank wins a tie
      if (liveCmd[r] && cmd == `DDR_CMD_RD) begin
        rdHit   = 1'b1;
        hitRank = 1'(r);
      end
      if (liveCmd[r] && cmd == `DDR_CMD_WR) begin
        wrHit   = 1'b1;
        hitRank = 1'(r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int r = 0; r < NR; r++) begin
      if (reset) begin
        pwr_r[r] <= ddr_pkg::PWR_ACT;
      end else begin
        case (pwr_r[r])
          ddr_pkg::PWR_ACT: begin
            if (ckRise && !ckeS[r]) begin
              if (srefCmd[r]) begin
                pwr_r[r] <= ddr_pkg::PWR_SREF;
              end else if (|open_r[r]) begin
                pwr_r[r] <= ddr_pkg::PWR_APD;
              end else begin
                pwr_r[r] <= ddr_pkg::PWR_PPD;
              end
            end
          end
          ddr_pkg::PWR_PPD, ddr_pkg::PWR_APD: begin
            if (ckRise && ckeS[r]) begin
              pwr_r[r] <= ddr_pkg::PWR_ACT;
            end
          end
          ddr_pkg::PWR_SREF: begin
            // Clock may be stopped here, so exit needs no clock edge
            if (ckeS[r]) begin
              pwr_r[r] <= ddr_pkg::PWR_ACT;
            end
          end
          default: pwr_r[r] <= ddr_pkg::PWR_ACT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Open banks and mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int r = 0; r < NR; r++) begin
      if (reset) begin
        open_r[r] <= '0;
      end else if (liveCmd[r]) begin
        if (cmd == `DDR_CMD_ACT) begin
          open_r[r][baS] <= 1'b1;
        end else if (cmd == `DDR_CMD_PRE) begin
          if (addrS[`DDR_A10]) begin
            open_r[r] <= '0;
          end else begin
            open_r[r][baS] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int r = 0; r < NR; r++) begin
      for (int m = 0; m < `DDR_NMR; m++) begin
        if (reset) begin
          mode_r[r][m] <= '0;
        end else if (liveCmd[r] && cmd == `DDR_CMD_LMR && !baS[2]
                     && baS[1:0] == 2'(m)) begin
          mode_r[r][m] <= addrS;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Rank status outputs
  // ----------------------------------------------------------------
  logic [NR-1:0] odtOn_r;
  logic [NR-1:0] clkActive_r;
  logic [NR-1:0] inBufOn_r;

  always_ff @(posedge clk) begin
    for (int r = 0; r < NR; r++) begin
      if (reset) begin
        odtOn_r[r]     <= 1'b0;
        clkActive_r[r] <= 1'b0;
        inBufOn_r[r]   <= 1'b0;
      end else begin
        clkActive_r[r] <= pwr_r[r] != ddr_pkg::PWR_SREF
                          && (pwr_r[r] == ddr_pkg::PWR_ACT
                              || ckeS[r]);
        inBufOn_r[r]   <= pwr_r[r] == ddr_pkg::PWR_ACT;
        if (!odtEn[r] || pwr_r[r] == ddr_pkg::PWR_SREF) begin
          odtOn_r[r] <= 1'b0;
        end else if (ckRise) begin
          odtOn_r[r] <= odtS[r];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage and write path
  // ----------------------------------------------------------------
  logic [DQW-1:0]         mem_r [2**IW];
  logic                   wrArm_r;
  logic [IW-1:0]          wrBase_r;
  logic [2:0]             wrBeat_r;
  logic [IW-1:0]          wrIdx;
  logic [DQW-1:0]         memPrev_r;

  assign wrIdx = {wrBase_r[IW-1:COLW],
                  COLW'(wrBase_r[COLW-1:0] + COLW'(wrBeat_r))};

  always_ff @(posedge clk) begin
    if (reset) begin
      wrArm_r  <= 1'b0;
      wrBase_r <= '0;
      wrBeat_r <= '0;
    end else if (wrHit) begin
      // Strobe must idle low until the first beat's rising edge
      wrArm_r  <= 1'b1;
      wrBase_r <= {hitRank, baS, addrS[COLW-1:0]};
      wrBeat_r <= '0;
    end else if (wrArm_r && dqsEdge) begin
      wrBeat_r <= wrBeat_r + 3'h1;
      if (wrBeat_r == 3'(`DDR_BL - 1)) begin
        wrArm_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    memPrev_r <= mem_r[wrIdx];
    if (wrArm_r && dqsEdge && !dmS) begin
      mem_r[wrIdx] <= dqS;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic                   rdPend_r;
  logic                   rdRun_r;
  logic [3:0]             rdWait_r;
  logic [2:0]             rdBeat_r;
  logic [IW-1:0]          rdBase_r;
  logic                   rdRank;
  logic [DQW-1:0]         dqOut_r;
  logic                   dqOe_r;
  logic                   dqsOut_r;
  logic                   dqsOe_r;
  logic                   dqsNOe_r;
  logic                   dqsNOut_r;
  logic [IW-1:0]          rdIdx;

  assign rdRank = rdBase_r[IW-1];
  assign rdIdx  = {rdBase_r[IW-1:COLW],
                   COLW'(rdBase_r[COLW-1:0] + COLW'(rdBeat_r))};

  always_ff @(posedge clk) begin
    if (reset) begin
      rdPend_r <= 1'b0;
      rdRun_r  <= 1'b0;
      rdWait_r <= '0;
      rdBeat_r <= '0;
      rdBase_r <= '0;
      dqOut_r  <= '0;
      dqOe_r   <= 1'b0;
      dqsOut_r <= 1'b0;
      dqsOe_r  <= 1'b0;
      dqsNOe_r <= 1'b0;
      dqsNOut_r <= 1'b1;
    end else if (rdHit) begin
      rdPend_r <= 1'b1;
      rdWait_r <= '0;
      rdBase_r <= {hitRank, baS, addrS[COLW-1:0]};
    end else if (rdPend_r && ckRise) begin
      // Latency counted in link clock cycles from the command
      rdWait_r <= rdWait_r + 4'h1;
      if (rdWait_r == 4'(RL - 1)) begin
        rdPend_r <= 1'b0;
        rdRun_r  <= 1'b1;
        rdBeat_r <= '0;
        dqsOe_r  <= 1'b1;
        dqsOut_r <= 1'b0;
        dqsNOut_r <= 1'b1;
        dqsNOe_r <= diffEn[rdRank];
      end
    end else if (rdRun_r && ckEdge) begin
      if (rdBeat_r == 3'(`DDR_BL)) begin
        rdRun_r  <= 1'b0;
        dqOe_r   <= 1'b0;
        dqsOe_r  <= 1'b0;
        dqsNOe_r <= 1'b0;
        dqsOut_r <= 1'b0;
        dqsNOut_r <= 1'b1;
      end else begin
        dqOe_r   <= 1'b1;
        dqOut_r  <= mem_r[rdIdx];
        dqsOut_r <= ~rdBeat_r[0];
        dqsNOut_r <= rdBeat_r[0];
        rdBeat_r <= rdBeat_r + 3'h1;
      end
    end
  end

  assign dqOut     = dqOut_r;
  assign dqOe      = dqOe_r;
  assign dqsOut    = dqsOut_r;
  assign dqsOe     = dqsOe_r;
  assign dqsNOut   = dqsNOut_r;
  assign dqsNOe    = dqsNOe_r;
  assign odtOn     = odtOn_r;
  assign clkActive = clkActive_r;
  assign inBufOn   = inBufOn_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_actOpen;
    liveCmd[0] && cmd == `DDR_CMD_ACT |=> open_r[0][$past(baS)];
  endproperty
  a_actOpen: assert property (p_actOpen)
    else $error("activate did not open bank");

  property p_modeLoad;
    liveCmd[0] && cmd == `DDR_CMD_LMR && baS == 3'h1
      |=> mode_r[0][`DDR_MR_EXT1] == $past(addrS);
  endproperty
  a_modeLoad: assert property (p_modeLoad)
    else $error("mode load missed register");

  property p_onlyRise;
    !ckRise |=> $stable(open_r[0]) && $stable(open_r[1]);
  endproperty
  a_onlyRise: assert property (p_onlyRise)
    else $error("bank state moved off a clock crossing");

  property p_csMask;
    ckRise && csNS[0] |=> $stable(open_r[0]) && $stable(mode_r[0][1]);
  endproperty
  a_csMask: assert property (p_csMask)
    else $error("deselected rank changed state");

  property p_apdEntry;
    ckRise && pwr_r[0] == ddr_pkg::PWR_ACT && !ckeS[0] && !srefCmd[0]
      && |open_r[0] |=> pwr_r[0] == ddr_pkg::PWR_APD;
  endproperty
  a_apdEntry: assert property (p_apdEntry)
    else $error("active power-down not entered");

  property p_srefExit;
    pwr_r[0] == ddr_pkg::PWR_SREF && ckeS[0] |=> pwr_r[0] == ddr_pkg::PWR_ACT;
  endproperty
  a_srefExit: assert property (p_srefExit)
    else $error("self refresh exit waited for clock");

  property p_srefDeaf;
    pwr_r[0] == ddr_pkg::PWR_SREF ##1 pwr_r[0] == ddr_pkg::PWR_SREF
      |-> $stable(open_r[0]) && !inBufOn_r[0];
  endproperty
  a_srefDeaf: assert property (p_srefDeaf)
    else $error("input seen in self refresh");

  property p_pdBuf;
    pwr_r[0] == ddr_pkg::PWR_PPD |=> !inBufOn_r[0];
  endproperty
  a_pdBuf: assert property (p_pdBuf)
    else $error("input buffers on in power-down");

  property p_maskDrop;
    wrArm_r && dqsEdge && dmS |=> mem_r[$past(wrIdx)] === memPrev_r;
  endproperty
  a_maskDrop: assert property (p_maskDrop)
    else $error("masked beat was written");

  property p_odtIgnore;
    !odtEn[0] |=> !odtOn_r[0];
  endproperty
  a_odtIgnore: assert property (p_odtIgnore)
    else $error("termination on while disabled");

  property p_diffStrobe;
    dqsNOe_r |-> dqsOe_r && diffEn[rdRank];
  endproperty
  a_diffStrobe: assert property (p_diffStrobe)
    else $error("complement strobe driven in single mode");

  c_read: cover property (rdRun_r && dqOe_r ##[1:20] !rdRun_r);
  c_write: cover property (wrArm_r && dqsEdge && !dmS);
  c_sref: cover property (pwr_r[0] == ddr_pkg::PWR_SREF ##[1:50]
                          pwr_r[0] == ddr_pkg::PWR_ACT);
  c_apd: cover property (pwr_r[0] == ddr_pkg::PWR_APD);
endmodule // ddr_pin_if
`default_nettype wire

// >>> rtl/ddr_cfg.svh
// Constants for the dual-rank DDR2 pin interface
`ifndef DDR_CFG_SVH
`define DDR_CFG_SVH
`define DDR_NRANK    2
`define DDR_NBANK    8
`define DDR_BAW      3
`define DDR_AW       15
`define DDR_DQW      8
`define DDR_COLW     3
`define DDR_NMR      4
`define DDR_RL       3
`define DDR_BL       4
`define DDR_A10      10
`define DDR_RTT_LO   2
`define DDR_RTT_HI   6
`define DDR_DQSN_OFF 10
`define DDR_MR_EXT1  2'h1
`define DDR_CMD_LMR  3'h0
`define DDR_CMD_REF  3'h1
`define DDR_CMD_PRE  3'h2
`define DDR_CMD_ACT  3'h3
`define DDR_CMD_WR   3'h4
`define DDR_CMD_RD   3'h5
`endif

// >>> rtl/ddr_pkg.sv
// Types shared by the DDR2 pin interface
package ddr_pkg;
  typedef enum logic [1:0] {PWR_ACT, PWR_PPD, PWR_APD, PWR_SREF} ddr_pwr_e;
  typedef logic [2:0] ddr_cmd_t;
endpackage

// >>> rtl/ddr_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module ddr_sync #(
  parameter int W = 1
) (
  // System
  input  wire logic         clk,
  input  wire logic         reset,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // ddr_sync
`default_nettype wire

// >>> verif/ddr_ctl_model.sv
// Controller-side model driving commands, termination and write data
`timescale 1ns/1ns
`default_nettype none
module ddr_ctl_model (
  // System
  input  wire logic        clk,
  // Command pins
  output var  logic        ck,
  output wire logic        ckN,
  output var  logic [1:0]  cke,
  output var  logic [1:0]  csN,
  output var  logic [1:0]  odt,
  output var  logic [2:0]  cmd,
  output var  logic [2:0]  ba,
  output var  logic [14:0] addr,
  // Write data pins
  output var  logic [7:0]  dq,
  output var  logic        dqs,
  output var  logic        dm
);
  assign ckN = ~ck;

  initial begin
    ck = 1'b0;
    cke = 2'h3;
    csN = 2'h3;
    odt = 2'h0;
    cmd = 3'h7;
    ba = 3'h0;
    addr = 15'h0000;
    dq = 8'h00;
    dqs = 1'b0;
    dm = 1'b0;
  end

  // --------------------------------------------------------------
  // Link tasks
  // --------------------------------------------------------------
  // Half a link period is four system clocks
  task automatic half(input logic lvl);
    @(posedge clk) ck <= lvl;
    repeat (3) @(posedge clk);
  endtask

  // Clock stands still outside these calls
  task automatic cycles(input int n);
    repeat (n) begin
      half(1'b1);
      half(1'b0);
    end
  endtask

  // Self refresh exit needs no link clock
  task automatic setCke(input logic [1:0] k);
    @(posedge clk) cke <= k;
  endtask

  // Inputs held four clocks before and eight clocks after the rising crossing
  task automatic send(input logic [1:0] s, input logic [2:0] c,
                      input logic [2:0] b, input logic [14:0] a,
                      input logic [1:0] k, input logic [1:0] o);
    @(posedge clk);
    csN  <= s;
    cmd  <= c;
    ba   <= b;
    addr <= a;
    cke  <= k;
    odt  <= o;
    repeat (3) @(posedge clk);
    half(1'b1);
    half(1'b0);
    @(posedge clk);
    csN  <= 2'h3;
    cmd  <= ~c;
    ba   <= ~b;
    addr <= ~a;
  endtask

  // Strobe edge sits mid-way in each seven-clock data eye
  task automatic burst(input logic [31:0] d, input logic [3:0] m);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      dq <= d[8*k +: 8];
      dm <= m[k];
      repeat (3) @(posedge clk);
      dqs <= ~dqs;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    dq <= ~dq;
    dm <= ~dm;
  endtask
endmodule // ddr_ctl_model
`default_nettype wire

// >>> verif/tb_ddr2_dual_rank_pin_interface.sv
// Self-checking bench for the dual-rank DDR2 pin interface
`timescale 1ns/1ns
`default_nettype none
`include "ddr_cfg.svh"
module tb_ddr2_dual_rank_pin_interface;
  logic        clk;
  logic        reset;
  wire         ck, ckN, ctlDqs, dm, dqOe, dqsOut, dqsOe, dqsNOut, dqsNOe;
  wire  [1:0]  cke, csN, odt, odtOn, clkActive, inBufOn;
  wire  [2:0]  cmd, ba;
  wire  [14:0] addr;
  wire  [7:0]  ctlDq, dqOut;
  wire  [7:0]  dqBus = dqOe ? dqOut : ctlDq;
  wire         dqsBus = dqsOe ? dqsOut : ctlDqs;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'h4a5a;
  logic [7:0]  mem [2][8][8];
  bit          vld [2][8][8];
  logic [1:0]  ckeV = 2'h3;
  logic [1:0]  odtV = 2'h0;
  logic [1:0]  diffOn = 2'h3;
  logic        expDiff = 1'b1;
  logic        lastDqs = 1'b0;
  logic [7:0]  rdQ [$];

  ddr_ctl_model ctl (.clk(clk), .ck(ck), .ckN(ckN), .cke(cke), .csN(csN),
    .odt(odt), .cmd(cmd), .ba(ba), .addr(addr), .dq(ctlDq), .dqs(ctlDqs),
    .dm(dm));
  ddr_pin_if #(.DQW(`DDR_DQW), .COLW(`DDR_COLW), .RL(`DDR_RL)) dut (
    .clk(clk), .reset(reset), .ck(ck), .ckN(ckN), .cke(cke), .csN(csN),
    .odt(odt), .rasN(cmd[2]), .casN(cmd[1]), .weN(cmd[0]), .ba(ba),
    .addr(addr), .dqIn(dqBus), .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsBus),
    .dqsOut(dqsOut), .dqsOe(dqsOe), .dqsNOut(dqsNOut), .dqsNOe(dqsNOe),
    .dm(dm), .odtOn(odtOn), .clkActive(clkActive), .inBufOn(inBufOn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Checking and helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // Each strobe change while data is driven carries one beat
  always @(posedge clk) begin
    lastDqs <= dqsOut;
    if (dqOe === 1'b1 && dqsOut !== lastDqs)
      rdQ.push_back(dqOut);
    if (dqsOe === 1'b1)
      check(dqsNOe, expDiff);
    if (dqsNOe === 1'b1)
      check(dqsNOut, !dqsOut);
  end

  function automatic logic [2:0] col(input logic [2:0] c, input int k);
    return c + 3'(k);
  endfunction

  task automatic go(input logic [1:0] s, input logic [2:0] c,
                    input logic [2:0] b, input logic [14:0] a);
    ctl.send(s, c, b, a, ckeV, odtV);
  endtask

  task automatic actAll(input int r);
    for (int b = 0; b < 8; b++)
      go(2'(~(2'h1 << r)), `DDR_CMD_ACT, 3'(b), 15'h0000);
  endtask

  // Beats land only when the rank is selected and awake
  task automatic wr(input logic [1:0] s, input int r, input logic [2:0] b,
                    input logic [2:0] c, input logic [31:0] d,
                    input logic [3:0] m);
    go(s, `DDR_CMD_WR, b, {12'h000, c});
    ctl.burst(d, m);
    if (!s[r] && ckeV[r]) begin
      for (int k = 0; k < 4; k++) begin
        if (!m[k]) begin
          mem[r][b][col(c, k)] = d[8*k +: 8];
          vld[r][b][col(c, k)] = 1'b1;
        end
      end
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic rd(input int r, input logic [2:0] b, input logic [2:0] c);
    expDiff = diffOn[r];
    rdQ.delete();
    go(2'(~(2'h1 << r)), `DDR_CMD_RD, b, {12'h000, c});
    ctl.cycles(7);
    check(rdQ.size(), 4);
    check({dqOe, dqsOe, dqsNOe}, 3'h0);
    for (int k = 0; k < rdQ.size(); k++) begin
      if (vld[r][b][col(c, k)])
        check(rdQ[k], mem[r][b][col(c, k)]);
    end
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int r;
    logic [2:0] b;
    logic [2:0] c;
    logic [31:0] d;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    check({dqOe, dqsOe, dqsNOe, dqsNOut}, 4'h1);
    @(posedge clk) reset <= 1'b0;
    repeat (4) @(posedge clk);
    check(clkActive, 2'h3);
    check(inBufOn, 2'h3);
    odtV = 2'h3;
    actAll(0);
    actAll(1);
    check(odtOn, 2'h0);
    $display("test reset done");
    // Only the first extended register turns termination on
    for (int m = 2; m < 4; m++)
      go(2'h2, `DDR_CMD_LMR, 3'(m), 15'h0004);
    go(2'h3, 3'h7, 3'h0, 15'h0000);
    check(odtOn, 2'h0);
    go(2'h2, `DDR_CMD_LMR, 3'h1, 15'h0404);
    go(2'h3, 3'h7, 3'h0, 15'h0000);
    check(odtOn, 2'h1);
    diffOn = 2'h2;
    $display("test termination done");
    wr(2'h2, 0, 3'h7, 3'h7, 32'h44332211, 4'h0);
    wr(2'h1, 1, 3'h7, 3'h7, 32'h88776655, 4'h0);
    wr(2'h2, 0, 3'h6, 3'h7, 32'hCCBBAA99, 4'h0);
    wr(2'h2, 0, 3'h1, 3'h0, 32'h0F0E0D0C, 4'h0);
    wr(2'h2, 0, 3'h7, 3'h7, 32'hDDDDDDDD, 4'h5);
    wr(2'h3, 0, 3'h7, 3'h7, 32'hEEEEEEEE, 4'h0);
    rd(0, 3'h7, 3'h7);
    rd(1, 3'h7, 3'h7);
    rd(0, 3'h6, 3'h7);
    $display("test data done");
    // Open rows, so rank 0 drops into active power-down
    ckeV = 2'h2;
    go(2'h3, 3'h7, 3'h0, 15'h0000);
    check(clkActive, 2'h2);
    check(inBufOn, 2'h2);
    wr(2'h2, 0, 3'h1, 3'h0, 32'h12345678, 4'h0);
    ckeV = 2'h3;
    go(2'h3, 3'h7, 3'h0, 15'h0000);
    check(clkActive, 2'h3);
    rd(0, 3'h1, 3'h0);
    $display("test power-down done");
    go(2'h2, `DDR_CMD_PRE, 3'h0, 15'h0400);
    // All banks idle now, so enable low gives precharge power-down
    ckeV = 2'h2;
    go(2'h3, 3'h7, 3'h0, 15'h0000);
    check(inBufOn, 2'h2);
    ckeV = 2'h3;
    go(2'h3, 3'h7, 3'h0, 15'h0000);
    check(inBufOn, 2'h3);
    ckeV = 2'h2;
    go(2'h2, `DDR_CMD_REF, 3'h0, 15'h0000);
    check(clkActive, 2'h2);
    check(odtOn, 2'h0);
    ckeV = 2'h3;
    ctl.setCke(2'h3);
    repeat (6) @(posedge clk);
    check(clkActive, 2'h3);
    actAll(0);
    check(odtOn, 2'h1);
    rd(0, 3'h7, 3'h7);
    $display("test self refresh done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed) & 1;
      b = 3'($random(seed));
      c = 3'($random(seed));
      d = $random(seed);
      if (d[0])
        wr((i % 9 == 0) ? 2'h3 : 2'(~(2'h1 << r)), r, b, c,
           $random(seed), 4'($random(seed)));
      else
        rd(r, b, c);
    end
    $display("test random done");
    wrap_up();
  end
endmodule // tb_ddr2_dual_rank_pin_interface
`default_nettype wire
